// File: design/tcb_timer_ctrl_b.v
// timer control register b: flags, alternate output and axi4-lite access
//
// Operation
// - every reset clears timer_ctrl_b to 00h
// - split mode only: low byte counter equal low compare sets low_compare_flag
// - low byte counter has no capture; only compare matches set low_compare_flag
// - compare match sets capture_compare_flag: full match, or high byte in split
// - external capture edge also sets capture_compare_flag
// - split mode only: low byte counter overflow sets low_overflow_flag
// - full overflow in 16-bit mode, high byte overflow in split, sets overflow_flag
// - reserved bit four always reads zero
// - polarity bit selects starting level of enabled alternate output
// - alternate waveform follows full timer, or low byte counter in split
// - polarity writes accepted anytime, applied on enable rising edge only
`include "tcb_defines.vh"
`default_nettype none

module tcb_timer_ctrl_b (
  input wire aclk,
  input wire aresetn,
  // timer context
  input wire split_mode_select,
  input wire alt_output_enable,
  input wire [15:0] counter_value,
  input wire [15:0] compare_value,
  input wire capture_edge,
  input wire low_carry,
  input wire high_carry,
  output wire alt_output_pin,
  output reg irq_q,
  // axi4-lite slave
  input wire [11:0] s_axil_awaddr,
  input wire [2:0] s_axil_awprot,
  input wire s_axil_awvalid,
  output reg s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output reg s_axil_wready,
  output reg [1:0] s_axil_bresp,
  output reg s_axil_bvalid,
  input wire s_axil_bready,
  input wire [11:0] s_axil_araddr,
  input wire [2:0] s_axil_arprot,
  input wire s_axil_arvalid,
  output reg s_axil_arready,
  output reg [31:0] s_axil_rdata,
  output reg [1:0] s_axil_rresp,
  output reg s_axil_rvalid,
  input wire s_axil_rready
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_CTRL = 2'h1;
  localparam [1:0] SEL_STAT = 2'h2;
  localparam [1:0] SEL_MASK = 2'h3;

  function [1:0] decode;
    input [11:0] addr;
    begin
      case (addr)
        `TCB_ADDR_CTRL_B: decode = SEL_CTRL;
        `TCB_ADDR_IRQ_STATUS: decode = SEL_STAT;
        `TCB_ADDR_IRQ_MASK: decode = SEL_MASK;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // compare and overflow events
  // ----------------------------------------------------------------
  wire low_eq;
  wire high_eq;
  wire low_onset;
  wire high_onset;
  reg full_eq_q;
  reg full_onset_q;

  tcb_byte_match u_low_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_byte(counter_value[7:0]),
    .compare_byte(compare_value[7:0]),
    .equal(low_eq),
    .onset_q(low_onset)
  );

  tcb_byte_match u_high_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_byte(counter_value[15:8]),
    .compare_byte(compare_value[15:8]),
    .equal(high_eq),
    .onset_q(high_onset)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      full_eq_q <= 1'b1;
      full_onset_q <= 1'b0;
    end else begin
      full_eq_q <= low_eq & high_eq;
      full_onset_q <= low_eq & high_eq & ~full_eq_q;
    end
  end

  // the match pulses lag the counter by one cycle; the carries are aligned to them
  reg low_carry_q;
  reg high_carry_q;
  reg capture_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      low_carry_q <= 1'b0;
      high_carry_q <= 1'b0;
      capture_q <= 1'b0;
    end else begin
      low_carry_q <= low_carry;
      high_carry_q <= high_carry;
      capture_q <= capture_edge;
    end
  end

  wire [`TCB_FLAG_W-1:0] evt;
  assign evt[`TCB_BIT_LOW_CMP] = split_mode_select & low_onset;
  assign evt[`TCB_BIT_CAP_CMP] = (split_mode_select ? high_onset : full_onset_q)
                                 | capture_q;
  assign evt[`TCB_BIT_LOW_OVF] = split_mode_select & low_carry_q;
  assign evt[`TCB_BIT_OVF] = high_carry_q;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  reg [11:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg have_aw_q;
  reg have_w_q;

  wire aw_fire = s_axil_awvalid & s_axil_awready;
  wire w_fire = s_axil_wvalid & s_axil_wready;
  wire aw_ok = have_aw_q | aw_fire;
  wire w_ok = have_w_q | w_fire;
  wire [11:0] wa = have_aw_q ? waddr_q : s_axil_awaddr;
  wire [31:0] wd = have_w_q ? wdata_q : s_axil_wdata;
  wire [3:0] ws = have_w_q ? wstrb_q : s_axil_wstrb;
  wire do_write = aw_ok & w_ok & ~s_axil_bvalid;
  wire [1:0] wsel = decode(wa);
  wire wlane = do_write & ws[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      waddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `TCB_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        waddr_q <= s_axil_awaddr;
      end
      if (w_fire) begin
        wdata_q <= s_axil_wdata;
        wstrb_q <= s_axil_wstrb;
      end
      have_aw_q <= aw_ok & ~do_write;
      have_w_q <= w_ok & ~do_write;
      s_axil_awready <= ~aw_ok & ~s_axil_bvalid & ~s_axil_awready;
      s_axil_wready <= ~w_ok & ~s_axil_bvalid & ~s_axil_wready;
      if (do_write) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= (wsel == SEL_NONE) ? `TCB_RESP_SLVERR : `TCB_RESP_OKAY;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer_ctrl_b and interrupt registers
  // ----------------------------------------------------------------
  reg [`TCB_FLAG_W-1:0] flags_q;
  reg polarity_q;
  reg [`TCB_FLAG_W-1:0] irq_status_q;
  reg [`TCB_FLAG_W-1:0] irq_mask_q;
  reg [`TCB_FLAG_W-1:0] flags_d;
  reg [`TCB_FLAG_W-1:0] irq_status_d;
  localparam [7:0] CTRL_B_RST = `TCB_CTRL_B_RESET;

  // a hardware event in the clearing cycle wins over the software write
  always @* begin
    flags_d = flags_q;
    if (wlane && wsel == SEL_CTRL) begin
      flags_d = wd[`TCB_FLAG_W-1:0];
    end
    flags_d = flags_d | evt;
    irq_status_d = irq_status_q;
    if (wlane && wsel == SEL_STAT) begin
      irq_status_d = irq_status_q & ~wd[`TCB_FLAG_W-1:0];
    end
    irq_status_d = irq_status_d | evt;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= CTRL_B_RST[`TCB_FLAG_W-1:0];
      polarity_q <= CTRL_B_RST[`TCB_BIT_POL];
      irq_status_q <= `TCB_IRQ_RESET;
      irq_mask_q <= `TCB_IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_status_q <= irq_status_d;
      if (wlane && wsel == SEL_CTRL) begin
        polarity_q <= wd[`TCB_BIT_POL];
      end
      if (wlane && wsel == SEL_MASK) begin
        irq_mask_q <= wd[`TCB_FLAG_W-1:0];
      end
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // alternate output
  // ----------------------------------------------------------------
  wire alt_toggle = split_mode_select ? low_onset : full_onset_q;

  tcb_alt_out u_alt (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(alt_output_enable),
    .polarity(polarity_q),
    .toggle(alt_toggle),
    .pin_q(alt_output_pin)
  );

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    case (decode(s_axil_araddr))
      SEL_CTRL: begin
        rd_d[`TCB_FLAG_W-1:0] = flags_q;
        rd_d[`TCB_BIT_RSVD] = 1'b0;
        rd_d[`TCB_BIT_POL] = polarity_q;
      end
      SEL_STAT: rd_d[`TCB_FLAG_W-1:0] = irq_status_q;
      SEL_MASK: rd_d[`TCB_FLAG_W-1:0] = irq_mask_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= `TCB_RESP_OKAY;
    end else begin
      s_axil_arready <= ~s_axil_rvalid & ~s_axil_arready & ~s_axil_arvalid;
      if (s_axil_arvalid & s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_d;
        s_axil_rresp <= (decode(s_axil_araddr) == SEL_NONE) ?
                        `TCB_RESP_SLVERR : `TCB_RESP_OKAY;
      end else if (s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
      if (s_axil_arvalid & ~s_axil_arready & ~s_axil_rvalid) begin
        s_axil_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: pkg/tcb_defines.vh
// constants for the timer control register b block
`ifndef TCB_DEFINES_VH
`define TCB_DEFINES_VH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define TCB_IDX_CTRL_B 8'h0B
`define TCB_IDX_IRQ_STATUS 8'h10
`define TCB_IDX_IRQ_MASK 8'h11
`define TCB_ADDR_CTRL_B 12'h02C
`define TCB_ADDR_IRQ_STATUS 12'h040
`define TCB_ADDR_IRQ_MASK 12'h044
`define TCB_ADDR_W 12

// ----------------------------------------------------------------
// timer_ctrl_b fields
// ----------------------------------------------------------------
`define TCB_BIT_LOW_CMP 0
`define TCB_BIT_CAP_CMP 1
`define TCB_BIT_LOW_OVF 2
`define TCB_BIT_OVF 3
`define TCB_BIT_RSVD 4
`define TCB_BIT_POL 5
`define TCB_CTRL_B_RESET 8'h00
`define TCB_CTRL_B_WMASK 8'h2F
`define TCB_FLAG_W 4
`define TCB_IRQ_RESET 4'h0

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define TCB_RESP_OKAY 2'h0
`define TCB_RESP_SLVERR 2'h2

`endif

// File: design/tcb_byte_match.v
// one byte comparator with match-onset pulse
`default_nettype none

module tcb_byte_match (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] count_byte,
  input wire [7:0] compare_byte,
  output wire equal,
  output reg onset_q
);

  reg equal_q;

  assign equal = (count_byte == compare_byte);

  // a held match sets the flag once, so a cleared flag stays cleared
  always @(posedge aclk) begin
    if (!aresetn) begin
      // starting as matched keeps a counter equal to compare at reset from setting a flag
      equal_q <= 1'b1;
      onset_q <= 1'b0;
    end else begin
      equal_q <= equal;
      onset_q <= equal & ~equal_q;
    end
  end

endmodule

`default_nettype wire

// File: design/tcb_alt_out.v
// alternate output pin waveform generator
`default_nettype none

module tcb_alt_out (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire polarity,
  input wire toggle,
  output reg pin_q
);

  reg enable_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      enable_q <= enable;
      if (enable & ~enable_q) begin
        pin_q <= polarity;
      end else if (enable & toggle) begin
        pin_q <= ~pin_q;
      end
    end
  end

endmodule

`default_nettype wire

// File: dv/tcb_timer_ctrl_b_sva.sv
// concurrent checks on the ports of timer control register b
`default_nettype none

module tcb_ctrl_b_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic alt_output_enable,
  input wire logic alt_output_pin,
  input wire logic irq_q,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // handshake steps
  // ----------------------------------------------------------------
  sequence wr_take;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence rd_take;
    s_axil_arvalid && s_axil_arready;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axil_bvalid && !s_axil_rvalid && !irq_q && !alt_output_pin) else $error("reset idle");
  wr_resp_a: assert property (wr_take |=> s_axil_bvalid) else $error("no write response");
  rd_resp_a: assert property (rd_take |=> s_axil_rvalid) else $error("no read response");
  b_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=>
    s_axil_bvalid && $stable(s_axil_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=>
    s_axil_rvalid && $stable(s_axil_rdata)) else $error("rdata dropped");
  rsvd_zero_a: assert property (s_axil_rvalid |->
    s_axil_rdata[31:6] == 26'h0 && !s_axil_rdata[4]) else $error("reserved bit set");
  err_zero_a: assert property (s_axil_rvalid && s_axil_rresp == 2'h2 |->
    s_axil_rdata == 32'h0) else $error("error read data");
  busy_stall_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write taken while busy");
  pin_still_a: assert property (!alt_output_enable [*3] |-> $stable(alt_output_pin))
    else $error("pin moved while disabled");
endmodule

bind tcb_timer_ctrl_b tcb_ctrl_b_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .alt_output_enable(alt_output_enable),
  .alt_output_pin(alt_output_pin), .irq_q(irq_q),
  .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
  .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
  .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready)
);

`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for timer control register b
`include "tcb_defines.vh"
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, split_mode_select, alt_output_enable, capture_edge, low_carry, high_carry;
  logic [15:0] counter_value, compare_value, cmp;
  logic alt_output_pin, irq_q;
  logic [11:0] s_axil_awaddr, s_axil_araddr;
  logic [2:0] s_axil_awprot, s_axil_arprot;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, eb;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic [33:0] rq[$], er;
  logic [1:0] bq[$];
  int n_fail, checks_done, cyc;

  tcb_timer_ctrl_b u_dut (
    .aclk(aclk), .aresetn(aresetn), .split_mode_select(split_mode_select),
    .alt_output_enable(alt_output_enable), .counter_value(counter_value),
    .compare_value(compare_value), .capture_edge(capture_edge), .low_carry(low_carry),
    .high_carry(high_carry), .alt_output_pin(alt_output_pin), .irq_q(irq_q),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awprot(s_axil_awprot),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arprot(s_axil_arprot), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready)
  );

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // response watcher and timeout
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      results();
    end else begin
      if (s_axil_bvalid && s_axil_bready) begin
        eb = bq.pop_front();
        `CHK("bresp", eb, s_axil_bresp)
      end
      if (s_axil_rvalid && s_axil_rready) begin
        er = rq.pop_front();
        `CHK("read", er, {s_axil_rresp, s_axil_rdata})
      end
    end
  end

  task results;
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    bq.push_back(r);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    aw = 1;
    w = 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axil_awready) begin
        aw = 0;
        s_axil_awvalid <= 1'b0;
      end
      if (w && s_axil_wready) begin
        w = 0;
        s_axil_wvalid <= 1'b0;
      end
    end
    // a late bready makes the slave hold its response for a few cycles
    repeat ($urandom % 3) @(posedge aclk);
    s_axil_bready <= 1'b1;
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
    rq.push_back({r, d});
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge aclk);
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
  endtask

  // counter shows cv for one cycle with pulses p = {capture, low carry, high carry}
  task ev(input logic [15:0] cv, input logic [2:0] p);
    counter_value <= cv;
    {capture_edge, low_carry, high_carry} <= p;
    @(posedge aclk);
    counter_value <= ~cmp;
    {capture_edge, low_carry, high_carry} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask

  task sc(input logic s, input logic [15:0] cv, input logic [2:0] p, input logic [31:0] e);
    split_mode_select <= s;
    @(posedge aclk);
    ev(cv, p);
    rd(`TCB_ADDR_CTRL_B, `TCB_RESP_OKAY, e);
    wr(`TCB_ADDR_CTRL_B, 32'h0, `TCB_RESP_OKAY);
  endtask

  // outputs read at an edge show what the edge before it registered
  task settle;
    repeat (3) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(94));
    cmp = 16'($urandom);
    {split_mode_select, alt_output_enable, capture_edge, low_carry, high_carry} = 5'h0;
    compare_value = cmp;
    counter_value = ~cmp;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 56'h0;
    {s_axil_awprot, s_axil_arprot} = 6'h0;
    s_axil_wstrb = 4'hF;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 5'h0;
    aresetn = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TCB_ADDR_CTRL_B, `TCB_RESP_OKAY, 32'h0);
    rd(`TCB_ADDR_IRQ_STATUS, `TCB_RESP_OKAY, 32'h0);
    rd(`TCB_ADDR_IRQ_MASK, `TCB_RESP_OKAY, 32'h0);
    rd(12'h100, `TCB_RESP_SLVERR, 32'h0);
    wr(12'h100, 32'hFF, `TCB_RESP_SLVERR);
    wr(`TCB_ADDR_CTRL_B, 32'hFF, `TCB_RESP_OKAY);
    rd(`TCB_ADDR_CTRL_B, `TCB_RESP_OKAY, 32'h2F);
    wr(`TCB_ADDR_CTRL_B, 32'h0, `TCB_RESP_OKAY);
    rd(`TCB_ADDR_CTRL_B, `TCB_RESP_OKAY, 32'h0);
    sc(1'b0, cmp, 3'h0, 32'h02);
    sc(1'b0, {cmp[15:8], ~cmp[7:0]}, 3'h0, 32'h00);
    sc(1'b0, ~cmp, 3'h2, 32'h00);
    sc(1'b0, ~cmp, 3'h1, 32'h08);
    sc(1'b1, {~cmp[15:8], cmp[7:0]}, 3'h0, 32'h01);
    sc(1'b1, {cmp[15:8], ~cmp[7:0]}, 3'h0, 32'h02);
    sc(1'b1, ~cmp, 3'h2, 32'h04);
    sc(1'b1, ~cmp, 3'h4, 32'h02);
    sc(1'b1, ~cmp, 3'h1, 32'h08);
    rd(`TCB_ADDR_IRQ_STATUS, `TCB_RESP_OKAY, 32'hF);
    `CHK("irq", 1'b0, irq_q)
    wr(`TCB_ADDR_IRQ_MASK, 32'h2, `TCB_RESP_OKAY);
    settle();
    `CHK("irq", 1'b1, irq_q)
    wr(`TCB_ADDR_IRQ_STATUS, 32'h2, `TCB_RESP_OKAY);
    settle();
    `CHK("irq", 1'b0, irq_q)
    rd(`TCB_ADDR_IRQ_STATUS, `TCB_RESP_OKAY, 32'hD);
    wr(`TCB_ADDR_CTRL_B, 32'h20, `TCB_RESP_OKAY);
    alt_output_enable <= 1'b1;
    settle();
    `CHK("pin", 1'b1, alt_output_pin)
    wr(`TCB_ADDR_CTRL_B, 32'h0, `TCB_RESP_OKAY);
    settle();
    `CHK("pin", 1'b1, alt_output_pin)
    split_mode_select <= 1'b0;
    ev(cmp, 3'h0);
    `CHK("pin", 1'b0, alt_output_pin)
    split_mode_select <= 1'b1;
    ev({~cmp[15:8], cmp[7:0]}, 3'h0);
    `CHK("pin", 1'b1, alt_output_pin)
    alt_output_enable <= 1'b0;
    settle();
    alt_output_enable <= 1'b1;
    settle();
    `CHK("pin", 1'b0, alt_output_pin)
    wr(`TCB_ADDR_CTRL_B, 32'hFF, `TCB_RESP_OKAY);
    `CHK("pin", 1'b0, alt_output_pin)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TCB_ADDR_CTRL_B, `TCB_RESP_OKAY, 32'h0);
    rd(`TCB_ADDR_IRQ_STATUS, `TCB_RESP_OKAY, 32'h0);
    results();
  end
endmodule

`default_nettype wire
